// *** src/shift_block_map.svh ***
// Constants of the dual mode shift block: register map, field layout,
// reset values. Assumes a 32-bit classic Wishbone slave with byte addressing.
//
// Functional notes
// - Format setting selects bit or word operation.
// - Reset selects single-bit format.
// - Bit mode takes forward and backward data bits.
// - Word inputs ignored in bit mode.
// - Word mode holds signed 32-bit values.
// - Each of eight word stages has output.
// - First word forward, second word backward.
// - Visibility flag, default shown.
// - Forward pulse loads stage one, shifts up.
// - Backward pulse loads stage eight, shifts down.
// - Inactive block ignores pulses and clear.
// - Clear zeroes all stages when active.
`ifndef SHIFT_BLOCK_MAP_SVH
`define SHIFT_BLOCK_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SB_CTRL_ADDR 8'h00
`define SB_STATUS_ADDR 8'h04
`define SB_STAGE0_ADDR 8'h20
`define SB_STAGE_LAST_ADDR 8'h3C

// ----------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------
`define SB_CTRL_FMT_BIT 0
`define SB_CTRL_SHOW_BIT 1
`define SB_FMT_RESET 1'b0
`define SB_SHOW_RESET 1'b1
`define SB_STAGE_RESET 32'h0000_0000
`define SB_READ_ZERO 32'h0000_0000

`endif

// *** src/shift_block_pkg.sv ***
// Types of the dual mode shift block.
// Assumes the constants header is included by its users.
package shift_block_pkg;
    typedef enum logic {
        fmt_single_bit,
        fmt_long_word
    } long_word_format_t;
endpackage

// *** src/edge_rise.sv ***
// Rising edge detector for a level already in the clock domain.
// Assumes its input is registered or synchronised upstream.
`timescale 1ns/1ps
module edge_rise (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic level_i,
    output logic rise_o
);
    logic last_reg;
    logic last_next;

    always_comb begin
        last_next = level_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_reg <= 1'b0;
        end else begin
            last_reg <= last_next;
        end
    end

    assign rise_o = level_i & ~last_reg;
endmodule // edge_rise

// *** src/shift_block.sv ***
// Eight-stage bidirectional shift block with bit and word formats.
// Assumes control pins arrive asynchronously and are synchronised here;
// word inputs pass the same synchronisers and must stand still around a pulse.
`timescale 1ns/1ps
`include "shift_block_map.svh"
module shift_block #(
    parameter int STAGES = 8,
    parameter int WIDTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic block_activate_i,
    input wire logic step_ahead_pulse_i,
    input wire logic step_back_pulse_i,
    input wire logic wipe_all_stages_i,
    input wire logic fwd_data_bit_i,
    input wire logic bwd_data_bit_i,
    input wire logic signed [WIDTH-1:0] word_in_ahead_i,
    input wire logic signed [WIDTH-1:0] word_in_back_i,
    output logic [STAGES-1:0] bit_stage_outs_o,
    output logic signed [WIDTH-1:0] word_stage_outs_o [STAGES],
    output logic params_shown_o,
    output logic long_word_format_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    // The stage map, the status word and the assertions assume this size.
    if (STAGES != 8 || WIDTH != 32) begin : g_size_check
        $error("shift_block supports eight 32-bit stages only");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Four control pins, two data bits and both words. The words are many
    // bits wide, so they only arrive coherent because the controller holds
    // them steady around a pulse; a shift sees them two cycles late.
    localparam int PIN_BITS = 6;
    localparam int SYNC_W = PIN_BITS + 2 * WIDTH;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] sync_next;

    always_comb begin
        sync_next = {word_in_back_i, word_in_ahead_i,
                     bwd_data_bit_i, fwd_data_bit_i, wipe_all_stages_i,
                     step_back_pulse_i, step_ahead_pulse_i,
                     block_activate_i};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= sync_next;
            sync2_reg <= sync1_reg;
        end
    end

    logic active_s;
    logic ahead_s;
    logic back_s;
    logic wipe_s;
    logic fwd_bit_s;
    logic bwd_bit_s;
    assign active_s = sync2_reg[0];
    assign ahead_s = sync2_reg[1];
    assign back_s = sync2_reg[2];
    assign wipe_s = sync2_reg[3];
    assign fwd_bit_s = sync2_reg[4];
    assign bwd_bit_s = sync2_reg[5];
    logic signed [WIDTH-1:0] ahead_word_s;
    logic signed [WIDTH-1:0] back_word_s;
    assign ahead_word_s = sync2_reg[PIN_BITS +: WIDTH];
    assign back_word_s = sync2_reg[PIN_BITS + WIDTH +: WIDTH];

    logic ahead_rise;
    logic back_rise;

    edge_rise u_ahead_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .level_i(ahead_s),
        .rise_o(ahead_rise)
    );

    edge_rise u_back_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .level_i(back_s),
        .rise_o(back_rise)
    );

    // ------------------------------------------------------------------
    // Settings registers
    // ------------------------------------------------------------------
    shift_block_pkg::long_word_format_t fmt_reg;
    shift_block_pkg::long_word_format_t fmt_next;
    logic show_reg;
    logic show_next;
    logic wb_hit;
    logic wb_write;

    assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // A write lands at the edge where the master samples ack high.
    assign wb_write = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

    always_comb begin
        fmt_next = fmt_reg;
        show_next = show_reg;
        if (wb_write && wb_adr_i == `SB_CTRL_ADDR) begin
            fmt_next = wb_dat_i[`SB_CTRL_FMT_BIT] ?
                shift_block_pkg::fmt_long_word :
                shift_block_pkg::fmt_single_bit;
            show_next = wb_dat_i[`SB_CTRL_SHOW_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fmt_reg <= shift_block_pkg::fmt_single_bit;
            show_reg <= `SB_SHOW_RESET;
        end else begin
            fmt_reg <= fmt_next;
            show_reg <= show_next;
        end
    end

    // ------------------------------------------------------------------
    // Stage storage
    // ------------------------------------------------------------------
    // Bit and word stages are kept apart so a format change never mixes
    // the two views; each stores only what its own format shifts in.
    logic [STAGES-1:0] bits_reg;
    logic [STAGES-1:0] bits_next;
    logic signed [WIDTH-1:0] words_reg [STAGES];
    logic signed [WIDTH-1:0] words_next [STAGES];
    logic is_word;
    assign is_word = (fmt_reg == shift_block_pkg::fmt_long_word);

    always_comb begin
        bits_next = bits_reg;
        words_next = words_reg;
        if (active_s) begin
            if (wipe_s) begin
                bits_next = '0;
                for (int i = 0; i < STAGES; i++) begin
                    words_next[i] = `SB_STAGE_RESET;
                end
            end else if (ahead_rise) begin
                if (is_word) begin
                    for (int i = STAGES - 1; i > 0; i--) begin
                        words_next[i] = words_reg[i-1];
                    end
                    words_next[0] = ahead_word_s;
                end else begin
                    bits_next = {bits_reg[STAGES-2:0], fwd_bit_s};
                end
            end else if (back_rise) begin
                if (is_word) begin
                    for (int i = 0; i < STAGES - 1; i++) begin
                        words_next[i] = words_reg[i+1];
                    end
                    words_next[STAGES-1] = back_word_s;
                end else begin
                    bits_next = {bwd_bit_s, bits_reg[STAGES-1:1]};
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bits_reg <= '0;
            for (int i = 0; i < STAGES; i++) begin
                words_reg[i] <= `SB_STAGE_RESET;
            end
        end else begin
            bits_reg <= bits_next;
            words_reg <= words_next;
        end
    end

    // Bit outputs only mean something in bit format, word outputs in word.
    // Registered from the next values, so they stay in step with the stages.
    logic [STAGES-1:0] bits_out_reg;
    logic [STAGES-1:0] bits_out_next;
    logic signed [WIDTH-1:0] words_out_reg [STAGES];
    logic signed [WIDTH-1:0] words_out_next [STAGES];
    logic is_word_next;
    assign is_word_next = (fmt_next == shift_block_pkg::fmt_long_word);

    always_comb begin
        bits_out_next = is_word_next ? '0 : bits_next;
        for (int i = 0; i < STAGES; i++) begin
            words_out_next[i] = is_word_next ? words_next[i] : '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bits_out_reg <= '0;
            for (int i = 0; i < STAGES; i++) begin
                words_out_reg[i] <= `SB_STAGE_RESET;
            end
        end else begin
            bits_out_reg <= bits_out_next;
            words_out_reg <= words_out_next;
        end
    end

    assign bit_stage_outs_o = bits_out_reg;
    assign word_stage_outs_o = words_out_reg;
    assign params_shown_o = show_reg;
    assign long_word_format_o = is_word;

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    // Single wait-free answer: ack one cycle after the strobe is seen.
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic [2:0] stage_idx;
    assign stage_idx = wb_adr_i[4:2];

    always_comb begin
        ack_next = wb_hit;
        rdat_next = rdat_reg;
        if (wb_hit && !wb_we_i) begin
            if (wb_adr_i == `SB_CTRL_ADDR) begin
                rdat_next = `SB_READ_ZERO;
                rdat_next[`SB_CTRL_FMT_BIT] = is_word;
                rdat_next[`SB_CTRL_SHOW_BIT] = show_reg;
            end else if (wb_adr_i == `SB_STATUS_ADDR) begin
                rdat_next = {{(32-STAGES){1'b0}}, bits_reg};
            end else if (wb_adr_i >= `SB_STAGE0_ADDR &&
                         wb_adr_i <= `SB_STAGE_LAST_ADDR &&
                         wb_adr_i[1:0] == 2'b00) begin
                rdat_next = words_reg[stage_idx];
            end else begin
                rdat_next = `SB_READ_ZERO;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= `SB_READ_ZERO;
        end else begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_reset_format: assert property (@(posedge clk_i)
        $past(rst_i) |-> !is_word)
        else $error("format not bit after reset");

    a_show_default: assert property (@(posedge clk_i)
        $past(rst_i) |-> show_reg)
        else $error("visibility not shown after reset");

    a_clear_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        active_s && wipe_s |=> bits_reg == '0 && words_reg[0] == 0)
        else $error("clear did not zero stages");

    a_idle_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        !active_s |=> $stable(bits_reg) && $stable(words_reg[7]))
        else $error("stages changed while inactive");

    a_fwd_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        active_s && !wipe_s && ahead_rise && !is_word |=>
        bits_reg == {$past(bits_reg[6:0]), $past(fwd_bit_s)})
        else $error("forward bit shift wrong");

    a_bwd_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        active_s && !wipe_s && !ahead_rise && back_rise && !is_word |=>
        bits_reg == {$past(bwd_bit_s), $past(bits_reg[7:1])})
        else $error("backward bit shift wrong");

    a_fwd_word: assert property (@(posedge clk_i) disable iff (rst_i)
        active_s && !wipe_s && ahead_rise && is_word |=>
        words_reg[0] == $past(ahead_word_s) &&
        words_reg[1] == $past(words_reg[0]))
        else $error("forward word shift wrong");

    a_bwd_word: assert property (@(posedge clk_i) disable iff (rst_i)
        active_s && !wipe_s && !ahead_rise && back_rise && is_word |=>
        words_reg[7] == $past(back_word_s) &&
        words_reg[6] == $past(words_reg[7]))
        else $error("backward word shift wrong");

    a_bit_ignores_word: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !is_word && !(active_s && wipe_s) |=> $stable(words_reg[0]))
        else $error("word stage changed in bit format");

    a_one_shift: assert property (@(posedge clk_i) disable iff (rst_i)
        ahead_rise |=> !ahead_rise)
        else $error("two shifts from one edge");

    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    sequence s_bus_request;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        s_bus_request |=> wb_ack_o)
        else $error("no ack after a bus request");

    a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
        wb_adr_i == `SB_CTRL_ADDR |=>
        is_word == $past(wb_dat_i[`SB_CTRL_FMT_BIT]))
        else $error("format write not applied");
endmodule // shift_block

// *** bench/shift_partner.sv ***
// Control program model that raises shift pulses with their data.
// Assumes the same clock as the shift block; tasks start at a clock edge.
`timescale 1ns/1ps
module shift_partner (
    input wire logic clk_i,
    output logic ahead_o,
    output logic back_o,
    output logic fwd_bit_o,
    output logic bwd_bit_o,
    output logic signed [31:0] word_a_o,
    output logic signed [31:0] word_b_o
);
    initial begin
        ahead_o = 1'b0;
        back_o = 1'b0;
        fwd_bit_o = 1'b0;
        bwd_bit_o = 1'b0;
        word_a_o = 32'h0000_0000;
        word_b_o = 32'h0000_0000;
    end

    task automatic step(input logic dir, input logic b, input logic [31:0] w);
        if (dir) begin
            bwd_bit_o <= b;
            word_b_o <= w;
        end else begin
            fwd_bit_o <= b;
            word_a_o <= w;
        end
        @(posedge clk_i);
        ahead_o <= ~dir;
        back_o <= dir;
        repeat (3) @(posedge clk_i);
        ahead_o <= 1'b0;
        back_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        // Data goes stale: invert it so a late capture shows up.
        fwd_bit_o <= ~fwd_bit_o;
        bwd_bit_o <= ~bwd_bit_o;
        word_a_o <= ~word_a_o;
        word_b_o <= ~word_b_o;
    endtask
endmodule // shift_partner

// *** bench/tb.sv ***
// Self-checking bench of the shift block with a control program model.
// Assumes one 250 MHz clock and a classic Wishbone register port.
`timescale 1ns/1ps
module tb;
    logic clk_i, rst_i, act, wipe, chk, ahead, back, fb, bb, shown, fmt;
    logic cyc, stb, we, ack, efmt, eshow;
    logic [7:0] adr, bits, ebit;
    logic [3:0] sel;
    logic [31:0] dw, dr, ew [8];
    logic signed [31:0] wa, wbk, words [8];
    logic [255:0] wo;
    logic [265:0] q [$], rq [$];
    int seed, errors, total_checks;

    shift_block shift_block_inst (.clk_i(clk_i), .rst_i(rst_i),
        .block_activate_i(act), .step_ahead_pulse_i(ahead),
        .step_back_pulse_i(back), .wipe_all_stages_i(wipe),
        .fwd_data_bit_i(fb), .bwd_data_bit_i(bb), .word_in_ahead_i(wa),
        .word_in_back_i(wbk), .bit_stage_outs_o(bits),
        .word_stage_outs_o(words), .params_shown_o(shown),
        .long_word_format_o(fmt), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
        .wb_dat_o(dr), .wb_ack_o(ack));
    shift_partner shift_partner_inst (.clk_i(clk_i), .ahead_o(ahead),
        .back_o(back), .fwd_bit_o(fb), .bwd_bit_o(bb), .word_a_o(wa),
        .word_b_o(wbk));

    // ------------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [265:0] s, e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s exp %h got %h", nm, e, s);
        end
    endtask

    always_comb begin
        for (int i = 0; i < 8; i++) wo[32*i +: 32] = words[i];
    end

    always @(posedge clk_i) begin
        if (chk) begin
            check("stages", {shown, fmt, bits, wo}, q.pop_front());
        end
        if (ack && !we) begin
            check("read", {234'h0, dr}, rq.pop_front());
        end
    end

    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    task automatic note();
        logic [255:0] w;
        for (int i = 0; i < 8; i++) w[32*i +: 32] = ew[i];
        // Stages of the other format read as zero.
        q.push_back({eshow, efmt, efmt ? 8'h00 : ebit, efmt ? w : 256'h0});
        chk <= 1'b1;
        @(posedge clk_i);
        chk <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wbx(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!ack && n < 20);
        if (!ack) begin
            errors++;
            end_of_test();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back({234'h0, e});
        wbx(1'b0, a, 32'h0000_0000);
    endtask

    task automatic op(input logic d, input logic [31:0] w);
        logic b;
        b = 1'($random(seed));
        shift_partner_inst.step(d, b, w);
        // Only the store of the current format moves.
        if (act && !wipe && !efmt) begin
            ebit = d ? {b, ebit[7:1]} : {ebit[6:0], b};
        end else if (act && !wipe && !d) begin
            for (int i = 7; i > 0; i--) ew[i] = ew[i-1];
            ew[0] = w;
        end else if (act && !wipe) begin
            for (int i = 0; i < 7; i++) ew[i] = ew[i+1];
            ew[7] = w;
        end
        note();
    endtask

    task automatic wipe_all(input logic with_shift);
        wipe <= 1'b1;
        repeat (4) @(posedge clk_i);
        if (act) begin
            ebit = 8'h00;
            for (int i = 0; i < 8; i++) ew[i] = 32'h0000_0000;
        end
        if (with_shift) op(1'b0, 32'h0000_0001);
        wipe <= 1'b0;
        repeat (4) @(posedge clk_i);
        note();
    endtask

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    initial begin
        {rst_i, eshow} = 2'b11;
        {act, wipe, chk, cyc, stb, we, efmt} = 7'h00;
        {adr, ebit, dw} = 48'h0;
        sel = 4'hf;
        seed = 32'hb64d_1b0a;
        for (int i = 0; i < 8; i++) ew[i] = 32'h0000_0000;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        note();
        rd(8'h00, 32'h0000_0002);
        rd(8'h10, 32'h0000_0000);
        act <= 1'b1;
        repeat (4) @(posedge clk_i);
        repeat (12) op(1'($random(seed)), $random(seed));
        rd(8'h04, {24'h0, ebit});
        rd(8'h20, ew[0]);
        act <= 1'b0;
        repeat (4) @(posedge clk_i);
        op(1'b0, $random(seed));
        op(1'b1, $random(seed));
        wipe_all(1'b1);
        act <= 1'b1;
        repeat (4) @(posedge clk_i);
        wipe_all(1'b1);
        wbx(1'b1, 8'h00, 32'h0000_0001);
        {eshow, efmt} = 2'b01;
        sel <= 4'he;
        wbx(1'b1, 8'h00, 32'h0000_0000);
        sel <= 4'hf;
        wipe_all(1'b0);
        repeat (12) op(1'($random(seed)), $random(seed));
        op(1'b0, 32'h8000_0000);
        op(1'b1, 32'h7fff_ffff);
        rd(8'h20, ew[0]);
        rd(8'h3C, ew[7]);
        rd(8'h04, {24'h0, ebit});
        wipe_all(1'b0);
        wbx(1'b1, 8'h00, 32'h0000_0002);
        {eshow, efmt} = 2'b10;
        note();
        end_of_test();
    end
endmodule // tb
